// ### core/bridge_chip_control_regs.sv
/*
 Bits 31 to 15 of the chip control register and the reserved word after it,
 with the credit update pacing, retry counter, discard, configuration retry
 and completion timers they steer. Assumes configuration accesses arrive
 as one-cycle requests on core_clk from either interface, test and strap
 pins synchronous to core_clk, and a reverse-select pin high for reverse mode.
*/
//
// Function
// - Field 0 sends credit update every two freed credits, 1 every credit.
// - Retry expiry sets sticky flag; write one or reset clears it.
// - Retry limit code picks unlimited, 256, 64K or 2G retries.
// - Discard timer disable bit 0 enables, 1 disables, with bridge control bit.
// - Short bit gives 64 clocks, else bridge control bit 24 or 25.
// - Configuration retry timer expires at 25us, 0.5ms, 5ms or 25ms.
// - Ordering bit 0 allows out-of-order delayed transactions, 1 forces order.
// - Completion timer expires at 50us, 10ms, 50ms, or is disabled.
// - Isochronous enable picks TC0 or the register traffic class.
// - Three-bit writable traffic class field resets to 001.
// - Loopback bit loops serial link when test pins match; read-only forward.
// - Lockout 0 accepts both interfaces, 1 only the secondary.
// - Locked primary access gets CRS forward, target retry reverse.
// - Lockout resets to 0 with test pin zero low; access depends direction.
// - Register after chip control is reserved, reads zero, ignores writes.
`timescale 1ns/100ps
`default_nettype none
`include "bridge_ctl_defs.svh"
module bridge_chip_control_regs
    import bridge_ctl_pkg::*;
#(
    parameter logic [31:0] CFG_RETRY_T1_CYC = 32'(`CFG_RETRY_T1_US * `CORE_CLK_MHZ),
    parameter logic [31:0] CFG_RETRY_T2_CYC = 32'(`CFG_RETRY_T2_US * `CORE_CLK_MHZ),
    parameter logic [31:0] CFG_RETRY_T3_CYC = 32'(`CFG_RETRY_T3_US * `CORE_CLK_MHZ),
    parameter logic [31:0] CPL_T0_CYC = 32'(`CPL_T0_US * `CORE_CLK_MHZ),
    parameter logic [31:0] CPL_T1_CYC = 32'(`CPL_T1_US * `CORE_CLK_MHZ),
    parameter logic [31:0] CPL_T2_CYC = 32'(`CPL_T2_US * `CORE_CLK_MHZ),
    parameter logic [31:0] DISC_SEL0_CYC = 32'(`DISC_SEL0_DEFAULT),
    parameter logic [31:0] DISC_SEL1_CYC = 32'(`DISC_SEL1_DEFAULT)
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cfg_req,
    input wire logic cfg_from_primary,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack_r,
    output logic cfg_crs_r,
    output logic cfg_retry_r,
    output logic [31:0] cfg_rdata_r,
    input wire logic test_select_pin_zero,
    input wire logic test_select_pin_one,
    input wire logic test_select_pin_two,
    input wire logic mask_input_pin,
    input wire logic reverse_bridge_select_pin,
    input wire logic bridge_ctl_discard_en,
    input wire logic bridge_ctl_primary_sel,
    input wire logic bridge_ctl_secondary_sel,
    input wire logic credit_freed,
    output logic fc_update_r,
    input wire logic retry_xact_active,
    input wire logic pci_retry_event,
    output logic retry_expired_r,
    output logic retry_sticky_r,
    input wire logic discard_pending,
    output logic discard_expired_r,
    input wire logic cfg_retry_pending,
    output logic cfg_retry_expired_r,
    input wire logic cpl_pending,
    output logic cpl_timeout_r,
    output logic in_order_r,
    output logic [2:0] mem_tc_r,
    output logic loopback_active_r
);
    localparam logic [31:0] CFG_RETRY_T0_CYC = 32'(`CFG_RETRY_T0_US * `CORE_CLK_MHZ);

    ctl_state_t cur_r;
    ctl_state_t cur_nxt;
    logic retry_hit;
    logic [31:0] retry_limit_cnt;
    logic [31:0] discard_limit_cnt;
    logic [31:0] cfg_retry_limit_cnt;
    logic [31:0] cpl_limit_cnt;

    function automatic logic [31:0] retry_count_of(input logic [1:0] code);
        case (code)
            `LIM_NONE: retry_count_of = 32'h00000000;
            `LIM_256: retry_count_of = `RETRIES_256;
            `LIM_64K: retry_count_of = `RETRIES_64K;
            default: retry_count_of = `RETRIES_2G;
        endcase
    endfunction

    function automatic logic [31:0] pick4(input logic [1:0] code, input logic [31:0] c0,
                                          input logic [31:0] c1, input logic [31:0] c2,
                                          input logic [31:0] c3);
        case (code)
            2'b00: pick4 = c0;
            2'b01: pick4 = c1;
            2'b10: pick4 = c2;
            default: pick4 = c3;
        endcase
    endfunction

    function automatic logic [31:0] cc0_image(input ctl_state_t s);
        cc0_image = {s.lockout, s.loopback, s.tc, s.iso_en, s.cpl_code, s.in_order,
                     s.cfg_retry_code, s.discard_short, s.discard_dis, s.retry_limit,
                     s.retry_sticky, s.fc_every_one, `LOW_FIELD_ZERO};
    endfunction

    // Retry counter of the transaction in progress
    assign retry_limit_cnt = retry_count_of(cur_r.retry_limit);

    interval_timer u_retry (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(retry_xact_active && (cur_r.retry_limit != `LIM_NONE)),
        .tick(pci_retry_event),
        .limit(retry_limit_cnt),
        .expired_r(retry_hit)
    );

    // Discard timer duration and enable
    assign discard_limit_cnt = cur_r.discard_short ? `DISC_SHORT_CLKS :
        ((reverse_bridge_select_pin ? bridge_ctl_secondary_sel : bridge_ctl_primary_sel) ?
         DISC_SEL1_CYC : DISC_SEL0_CYC);

    interval_timer u_discard (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(discard_pending && !cur_r.discard_dis && bridge_ctl_discard_en),
        .tick(1'b1),
        .limit(discard_limit_cnt),
        .expired_r(discard_expired_r)
    );

    assign cfg_retry_limit_cnt = pick4(cur_r.cfg_retry_code, CFG_RETRY_T0_CYC,
                                       CFG_RETRY_T1_CYC, CFG_RETRY_T2_CYC, CFG_RETRY_T3_CYC);

    interval_timer u_cfg_retry (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(cfg_retry_pending),
        .tick(1'b1),
        .limit(cfg_retry_limit_cnt),
        .expired_r(cfg_retry_expired_r)
    );

    assign cpl_limit_cnt = pick4(cur_r.cpl_code, CPL_T0_CYC, CPL_T1_CYC, CPL_T2_CYC,
                                 32'h00000000);

    interval_timer u_cpl (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(cpl_pending && (cur_r.cpl_code != `CPL_DISABLED)),
        .tick(1'b1),
        .limit(cpl_limit_cnt),
        .expired_r(cpl_timeout_r)
    );

    always_comb begin
        logic hit_cc0;
        logic hit_rsvd;
        logic locked_out;
        logic wr_ok;
        hit_cc0 = ({cfg_addr[7:2], `ADDR_LSB_ZERO} == `CC0_OFFSET);
        hit_rsvd = ({cfg_addr[7:2], `ADDR_LSB_ZERO} == `RSVD_OFFSET);
        locked_out = cur_r.lockout && cfg_from_primary;
        wr_ok = cfg_req && cfg_write && hit_cc0 && !locked_out;
        cur_nxt = cur_r;
        cur_nxt.ack = 1'b0;
        cur_nxt.crs = 1'b0;
        cur_nxt.retry = 1'b0;
        cur_nxt.fc_update = 1'b0;

        // Configuration answers
        if (cfg_req) begin
            if (locked_out) begin
                cur_nxt.crs = !reverse_bridge_select_pin;
                cur_nxt.retry = reverse_bridge_select_pin;
            end else begin
                cur_nxt.ack = 1'b1;
                cur_nxt.rdata = hit_cc0 ? cc0_image(cur_r) : `RSVD_VALUE;
            end
        end
        if (cfg_req && !locked_out && hit_rsvd) begin
            cur_nxt.rdata = `RSVD_VALUE;
        end

        // Register writes by byte lane
        if (wr_ok && cfg_be[`BYTE1]) begin
            cur_nxt.fc_every_one = cfg_wdata[`FC_UPD_BIT];
        end
        if (wr_ok && cfg_be[`BYTE2]) begin
            cur_nxt.retry_limit = cfg_wdata[`RETRY_LIM_HI:`RETRY_LIM_LO];
            cur_nxt.discard_dis = cfg_wdata[`DISC_DIS_BIT];
            cur_nxt.discard_short = cfg_wdata[`DISC_SHORT_BIT];
            cur_nxt.cfg_retry_code = cfg_wdata[`CFG_RETRY_HI:`CFG_RETRY_LO];
            cur_nxt.in_order = cfg_wdata[`ORDER_BIT];
        end
        if (wr_ok && cfg_be[`BYTE3]) begin
            cur_nxt.cpl_code = cfg_wdata[`CPL_HI:`CPL_LO];
            cur_nxt.iso_en = cfg_wdata[`ISO_EN_BIT];
            cur_nxt.tc = cfg_wdata[`TC_HI:`TC_LO];
            if (reverse_bridge_select_pin) begin
                cur_nxt.loopback = cfg_wdata[`LOOPBACK_BIT];
            end else begin
                cur_nxt.lockout = cfg_wdata[`LOCKOUT_BIT];
            end
        end

        // Sticky retry flag, set wins over clear
        if (wr_ok && cfg_be[`BYTE2] && cfg_wdata[`RETRY_STS_BIT]) begin
            cur_nxt.retry_sticky = 1'b0;
        end
        if (retry_hit) begin
            cur_nxt.retry_sticky = 1'b1;
        end

        // Lockout strap caught once after reset release
        if (!cur_r.strap_done) begin
            cur_nxt.strap_done = 1'b1;
            cur_nxt.lockout = test_select_pin_zero;
        end

        // Credit update pacing
        if (credit_freed) begin
            if (cur_r.fc_every_one) begin
                cur_nxt.fc_update = 1'b1;
            end else if (cur_r.fc_half) begin
                cur_nxt.fc_update = 1'b1;
                cur_nxt.fc_half = 1'b0;
            end else begin
                cur_nxt.fc_half = 1'b1;
            end
        end
        if (cur_r.fc_every_one) begin
            cur_nxt.fc_half = 1'b0;
        end

        cur_nxt.mem_tc = cur_r.iso_en ? cur_r.tc : `TC_ZERO;
        cur_nxt.loop_active = cur_r.loopback && !test_select_pin_zero && test_select_pin_one &&
                              test_select_pin_two && mask_input_pin && reverse_bridge_select_pin;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cur_r <= '0;
            cur_r.fc_every_one <= `RST_BIT;
            cur_r.retry_sticky <= `RST_BIT;
            cur_r.retry_limit <= `RST_RETRY_LIM;
            cur_r.cfg_retry_code <= `RST_CFG_RETRY;
            cur_r.cpl_code <= `RST_CPL;
            cur_r.tc <= `RST_TC;
            cur_r.lockout <= `RST_BIT;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign cfg_ack_r = cur_r.ack;
    assign cfg_crs_r = cur_r.crs;
    assign cfg_retry_r = cur_r.retry;
    assign cfg_rdata_r = cur_r.rdata;
    assign fc_update_r = cur_r.fc_update;
    assign retry_expired_r = retry_hit;
    assign retry_sticky_r = cur_r.retry_sticky;
    assign in_order_r = cur_r.in_order;
    assign mem_tc_r = cur_r.mem_tc;
    assign loopback_active_r = cur_r.loop_active;
endmodule
`default_nettype wire

// ### core/bridge_ctl_defs.svh
/*
 Register offsets, field positions, reset values and timing figures of the
 chip control register bank. Assumes inclusion by bare name from core/.
*/
`ifndef BRIDGE_CTL_DEFS_SVH
`define BRIDGE_CTL_DEFS_SVH

// Register byte offsets
`define CC0_OFFSET 8'h40
`define RSVD_OFFSET 8'h44
`define RSVD_VALUE 32'h00000000
`define ADDR_LSB_ZERO 2'b00

// Field positions in the chip control register
`define FC_UPD_BIT 15
`define RETRY_STS_BIT 16
`define RETRY_LIM_LO 17
`define RETRY_LIM_HI 18
`define DISC_DIS_BIT 19
`define DISC_SHORT_BIT 20
`define CFG_RETRY_LO 21
`define CFG_RETRY_HI 22
`define ORDER_BIT 23
`define CPL_LO 24
`define CPL_HI 25
`define ISO_EN_BIT 26
`define TC_LO 27
`define TC_HI 29
`define LOOPBACK_BIT 30
`define LOCKOUT_BIT 31
`define LOW_FIELD_ZERO 15'h0000

// Byte lanes holding the fields
`define BYTE1 1
`define BYTE2 2
`define BYTE3 3

// Reset values
`define RST_BIT 1'b0
`define RST_RETRY_LIM 2'b00
`define RST_CFG_RETRY 2'b01
`define RST_CPL 2'b01
`define RST_TC 3'b001
`define TC_ZERO 3'b000

// Retry limit codes and counts
`define LIM_NONE 2'b00
`define LIM_256 2'b01
`define LIM_64K 2'b10
`define RETRIES_256 32'h00000100
`define RETRIES_64K 32'h00010000
`define RETRIES_2G 32'h80000000
`define CPL_DISABLED 2'b11

// Clock rate and timing figures
`define CORE_CLK_MHZ 100
`define CFG_RETRY_T0_US 25
`define CFG_RETRY_T1_US 500
`define CFG_RETRY_T2_US 5000
`define CFG_RETRY_T3_US 25000
`define CPL_T0_US 50
`define CPL_T1_US 10000
`define CPL_T2_US 50000
`define DISC_SHORT_CLKS 32'h00000040
`define DISC_SEL0_DEFAULT 32768
`define DISC_SEL1_DEFAULT 1024

`endif

// ### core/bridge_ctl_pkg.sv
/*
 Types of the chip control register bank.
 Assumes bridge_ctl_defs.svh for the figures.
*/
package bridge_ctl_pkg;

    typedef struct packed {
        logic [31:0] count;
        logic done;
        logic expired;
    } timer_state_t;

    typedef struct packed {
        logic fc_every_one;
        logic retry_sticky;
        logic [1:0] retry_limit;
        logic discard_dis;
        logic discard_short;
        logic [1:0] cfg_retry_code;
        logic in_order;
        logic [1:0] cpl_code;
        logic iso_en;
        logic [2:0] tc;
        logic loopback;
        logic lockout;
        logic strap_done;
        logic ack;
        logic crs;
        logic retry;
        logic [31:0] rdata;
        logic fc_half;
        logic fc_update;
        logic loop_active;
        logic [2:0] mem_tc;
    } ctl_state_t;

endpackage

// ### core/interval_timer.sv
/*
 Up counter that counts ticks while run is high and pulses once on reaching
 the limit. Assumes one clock core_clk and asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module interval_timer
    import bridge_ctl_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic tick,
    input wire logic [31:0] limit,
    output logic expired_r
);
    timer_state_t cur_r;
    timer_state_t cur_nxt;

    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.expired = 1'b0;
        if (!run) begin
            cur_nxt.count = 32'h00000000;
            cur_nxt.done = 1'b0;
        end else if (tick && !cur_r.done) begin
            if (cur_r.count + 32'h00000001 == limit) begin
                cur_nxt.count = limit;
                cur_nxt.done = 1'b1;
                cur_nxt.expired = 1'b1;
            end else begin
                cur_nxt.count = cur_r.count + 32'h00000001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign expired_r = cur_r.expired;
endmodule
`default_nettype wire

// ### dv/bridge_chip_control_regs_bench.sv
/* Self-checking bench of the chip control register bank.
   Assumes the design package and the far side model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module bridge_chip_control_regs_bench;
    logic core_clk, resetn, cfg_req, cfg_from_primary, cfg_write, cfg_ack_r, cfg_crs_r, cfg_retry_r;
    logic test_select_pin_zero, test_select_pin_one, test_select_pin_two, mask_input_pin;
    logic reverse_bridge_select_pin, bridge_ctl_discard_en, bridge_ctl_primary_sel, bridge_ctl_secondary_sel;
    logic credit_freed, fc_update_r, retry_xact_active, pci_retry_event, retry_expired_r, retry_sticky_r;
    logic discard_pending, discard_expired_r, cfg_retry_pending, cfg_retry_expired_r, cpl_pending;
    logic cpl_timeout_r, in_order_r, loopback_active_r, m_start, m_slow, m_busy, prim, wr;
    logic [7:0] cfg_addr, a;
    logic [3:0] cfg_be, be;
    logic [2:0] mem_tc_r, resp;
    logic [15:0] m_cred, m_retry;
    logic [31:0] cfg_wdata, cfg_rdata_r, img, got, d;
    int error_cnt, checked, n, fc_cnt, exp_cnt;
    int exp_t [13] = '{2500, 30, 40, 50, 5000, 70, 80, 6000, 64, 1024, 32768, 6000, 6000};
    logic [31:0] add_t [13] = '{32'h0, 32'h200000, 32'h400000, 32'h600000, 32'h0, 32'h1000000,
        32'h2000000, 32'h3000000, 32'h100000, 32'h0, 32'h0, 32'h80000, 32'h0};
    bridge_chip_control_regs #(.CFG_RETRY_T1_CYC(30), .CFG_RETRY_T2_CYC(40), .CFG_RETRY_T3_CYC(50),
        .CPL_T1_CYC(70), .CPL_T2_CYC(80))
    bridge_chip_control_regs_inst (.core_clk, .resetn, .cfg_req, .cfg_from_primary, .cfg_write, .cfg_addr,
        .cfg_be, .cfg_wdata, .cfg_ack_r, .cfg_crs_r, .cfg_retry_r, .cfg_rdata_r, .test_select_pin_zero,
        .test_select_pin_one, .test_select_pin_two, .mask_input_pin, .reverse_bridge_select_pin,
        .bridge_ctl_discard_en, .bridge_ctl_primary_sel, .bridge_ctl_secondary_sel, .credit_freed,
        .fc_update_r, .retry_xact_active, .pci_retry_event, .retry_expired_r, .retry_sticky_r,
        .discard_pending, .discard_expired_r, .cfg_retry_pending, .cfg_retry_expired_r, .cpl_pending,
        .cpl_timeout_r, .in_order_r, .mem_tc_r, .loopback_active_r);
    far_side_model far_side_model_inst (.core_clk, .resetn, .start(m_start), .slow(m_slow),
        .credit_n(m_cred), .retry_n(m_retry), .credit_freed, .pci_retry_event, .busy(m_busy));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (fc_update_r === 1'b1) fc_cnt++;
        if (retry_expired_r === 1'b1) exp_cnt++;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Expected image after a write; bit 16 clears on one
    function automatic logic [31:0] wr_exp(input logic [31:0] old, w, input logic [3:0] b, input logic rev);
        logic [31:0] m;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, 8'h00} & 32'hbffe8000;
        m[30] = b[3] & rev;
        m[31] = b[3] & !rev;
        wr_exp = (old & ~m) | (w & m);
        wr_exp[16] = old[16] & !(b[2] & w[16]);
    endfunction
    task automatic acc(input logic p, input logic w, input logic [7:0] ad, input logic [3:0] b,
        input logic [31:0] dat);
        @(posedge core_clk); #1;
        {cfg_req, cfg_from_primary, cfg_write, cfg_addr, cfg_be, cfg_wdata} = {1'b1, p, w, ad, b, dat};
        @(posedge core_clk); #1;
        cfg_req = 1'b0;
        resp = {cfg_retry_r, cfg_crs_r, cfg_ack_r};
        got = cfg_rdata_r;
    endtask
    task automatic wr40(input logic [31:0] v);
        acc(1'b0, 1'b1, 8'h40, 4'hf, v);
        img = wr_exp(img, v, 4'hf, reverse_bridge_select_pin);
    endtask
    task automatic feed(input int cr, input int rt, input logic sl);
        {m_cred, m_retry, m_slow, m_start} = {16'(cr), 16'(rt), sl, 1'b1};
        @(posedge core_clk); #1;
        m_start = 1'b0;
        for (n = 0; m_busy; n++) begin
            @(posedge core_clk); #1;
            if (n > 2000) begin
                error_cnt++;
                complete_run();
            end
        end
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic meas(input int which, input int lim);
        for (n = 1; n < lim; n++) begin
            @(posedge core_clk); #1;
            if ((which == 0 && cfg_retry_expired_r) || (which == 1 && cpl_timeout_r)
                || (which == 2 && discard_expired_r)) break;
        end
    endtask
    initial begin
        {cfg_req, cfg_from_primary, cfg_write, cfg_addr, cfg_be, cfg_wdata} = '0;
        {test_select_pin_zero, test_select_pin_one, test_select_pin_two, mask_input_pin} = 4'h1;
        {reverse_bridge_select_pin, bridge_ctl_discard_en, bridge_ctl_primary_sel} = 3'h1;
        {bridge_ctl_secondary_sel, retry_xact_active, discard_pending, cfg_retry_pending, cpl_pending} = '0;
        {m_start, m_slow, m_cred, m_retry, error_cnt, checked, fc_cnt, exp_cnt} = '0;
        void'($urandom(65));
        resetn = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 resetn = 1'b1;
        img = 32'h09200000;
        acc(1'b1, 1'b0, 8'h40, 4'hf, 32'h0);
        check("reset image", got, img);
        for (int i = 0; i < 60; i++) begin
            {prim, wr, be, d} = 38'({$urandom, $urandom});
            a = 8'h40 + 8'(($urandom % 3) * 4);
            acc(prim, wr, a, be, d);
            if (prim && img[31]) check("locked answer", resp, 3'b010);
            else begin
                check("answer", resp, 3'b001);
                if (!wr) check("read data", got, a == 8'h40 ? img : 32'h0);
                else if (a == 8'h40) img = wr_exp(img, d, be, 1'b0);
            end
        end
        wr40(32'h2c320000);
        @(posedge core_clk); #1;
        check("iso tc", mem_tc_r, 3'b101);
        check("order", in_order_r, 1'b0);
        wr40(32'h28b20000);
        @(posedge core_clk); #1;
        check("tc zero", mem_tc_r, 3'b000);
        check("order", in_order_r, 1'b1);
        fc_cnt = 0;
        feed(6, 0, 1'b0);
        check("updates by two", fc_cnt, 3);
        wr40(32'h28b28000);
        fc_cnt = 0;
        feed(5, 0, 1'b1);
        check("updates by one", fc_cnt, 5);
        retry_xact_active = 1'b1;
        feed(0, 255, 1'b0);
        check("no expiry at 255", exp_cnt, 0);
        feed(0, 1, 1'b0);
        check("expiry at 256", exp_cnt, 1);
        check("sticky", retry_sticky_r, 1'b1);
        acc(1'b0, 1'b1, 8'h40, 4'h4, 32'h00010000);
        acc(1'b0, 1'b0, 8'h40, 4'hf, 32'h0);
        check("sticky cleared", got[16], 1'b0);
        wr40(32'h28b00000);
        feed(0, 300, 1'b0);
        check("unlimited", exp_cnt, 1);
        for (int k = 0; k < 13; k++) begin
            wr40(32'h28820000 | add_t[k]);
            bridge_ctl_primary_sel = k == 9;
            bridge_ctl_discard_en = k != 12;
            {cfg_retry_pending, cpl_pending, discard_pending} = {k < 4, k > 3 && k < 8, k > 7};
            meas(k < 4 ? 0 : (k < 8 ? 1 : 2), k == 10 ? 33000 : 6000);
            check("timer length", n, exp_t[k]);
            {cfg_retry_pending, cpl_pending, discard_pending} = 3'h0;
        end
        wr40(32'h80000000);
        acc(1'b1, 1'b0, 8'h40, 4'hf, 32'h0);
        check("forward locked", resp, 3'b010);
        reverse_bridge_select_pin = 1'b1;
        acc(1'b1, 1'b0, 8'h40, 4'hf, 32'h0);
        check("reverse locked", resp, 3'b100);
        wr40(32'h40000000);
        acc(1'b0, 1'b0, 8'h40, 4'hf, 32'h0);
        check("reverse image", got, img);
        {test_select_pin_one, test_select_pin_two} = 2'h3;
        repeat (2) @(posedge core_clk);
        #1 check("loopback", loopback_active_r, 1'b1);
        test_select_pin_zero = 1'b1;
        resetn = 1'b0;
        #20 resetn = 1'b1;
        acc(1'b0, 1'b0, 8'h40, 4'hf, 32'h0);
        check("strap lockout", got, 32'h89200000);
        complete_run();
    end
endmodule
`default_nettype wire

// ### dv/bridge_ctl_chk.sv
/* Checker for the chip control register bank.
   Assumes it is bound onto bridge_chip_control_regs, one clock core_clk. */
`timescale 1ns/100ps
`default_nettype none
module bridge_ctl_chk (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cfg_req,
    input wire logic cfg_from_primary,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic cfg_ack_r,
    input wire logic cfg_crs_r,
    input wire logic cfg_retry_r,
    input wire logic [31:0] cfg_rdata_r,
    input wire logic test_select_pin_zero,
    input wire logic test_select_pin_one,
    input wire logic test_select_pin_two,
    input wire logic mask_input_pin,
    input wire logic reverse_bridge_select_pin,
    input wire logic bridge_ctl_discard_en,
    input wire logic credit_freed,
    input wire logic fc_update_r,
    input wire logic pci_retry_event,
    input wire logic retry_expired_r,
    input wire logic retry_sticky_r,
    input wire logic discard_expired_r,
    input wire logic loopback_active_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_req; cfg_req; endsequence
    sequence s_rsvd_rd; cfg_req && !cfg_write && cfg_addr[7:2] == 6'h11; endsequence
    property p_one_answer; s_req |=> $onehot({cfg_ack_r, cfg_crs_r, cfg_retry_r}); endproperty
    a_one_answer: assert property (p_one_answer) else $error("not exactly one answer");
    property p_sec_ack; cfg_req && !cfg_from_primary |=> cfg_ack_r; endproperty
    a_sec_ack: assert property (p_sec_ack) else $error("secondary access not acked");
    property p_crs_fwd; cfg_crs_r |-> $past(cfg_from_primary) && !$past(reverse_bridge_select_pin); endproperty
    a_crs_fwd: assert property (p_crs_fwd) else $error("crs outside forward primary");
    property p_retry_rev; cfg_retry_r |-> $past(cfg_from_primary) && $past(reverse_bridge_select_pin); endproperty
    a_retry_rev: assert property (p_retry_rev) else $error("retry outside reverse primary");
    property p_rsvd_zero; s_rsvd_rd |=> !cfg_ack_r || cfg_rdata_r == 32'h00000000; endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero");
    property p_sticky_set; $rose(retry_sticky_r) |-> $past(retry_expired_r); endproperty
    a_sticky_set: assert property (p_sticky_set) else $error("sticky set without expiry");
    property p_sticky_hold;
        retry_sticky_r && !(cfg_req && cfg_write && cfg_addr[7:2] == 6'h10 && cfg_be[2] && cfg_wdata[16])
            |=> retry_sticky_r;
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag lost");
    property p_expire_cause; retry_expired_r |-> $past(pci_retry_event); endproperty
    a_expire_cause: assert property (p_expire_cause) else $error("expiry without retry");
    property p_fc_cause; fc_update_r |-> $past(credit_freed); endproperty
    a_fc_cause: assert property (p_fc_cause) else $error("update without freed credit");
    property p_loop_pins;
        loopback_active_r |-> $past(reverse_bridge_select_pin && test_select_pin_one && test_select_pin_two
            && mask_input_pin && !test_select_pin_zero);
    endproperty
    a_loop_pins: assert property (p_loop_pins) else $error("loopback with wrong pins");
    property p_discard_en; discard_expired_r |-> $past(bridge_ctl_discard_en); endproperty
    a_discard_en: assert property (p_discard_en) else $error("discard expiry while disabled");
endmodule
bind bridge_chip_control_regs bridge_ctl_chk bridge_ctl_chk_inst (.core_clk, .resetn, .cfg_req,
    .cfg_from_primary, .cfg_write, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack_r, .cfg_crs_r, .cfg_retry_r,
    .cfg_rdata_r, .test_select_pin_zero, .test_select_pin_one, .test_select_pin_two, .mask_input_pin,
    .reverse_bridge_select_pin, .bridge_ctl_discard_en, .credit_freed, .fc_update_r, .pci_retry_event,
    .retry_expired_r, .retry_sticky_r, .discard_expired_r, .loopback_active_r);
`default_nettype wire

// ### dv/far_side_model.sv
/* Link and bus agents: free credits and retry one transaction on command.
   Assumes core_clk and active-low resetn of the block. */
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic slow,
    input wire logic [15:0] credit_n,
    input wire logic [15:0] retry_n,
    output logic credit_freed,
    output logic pci_retry_event,
    output logic busy
);
    logic [15:0] cred_r, retry_r;
    logic [1:0] gap_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {cred_r, retry_r, gap_r, credit_freed, pci_retry_event} <= '0;
        end else if (start) begin
            {cred_r, retry_r, gap_r, credit_freed, pci_retry_event} <= {credit_n, retry_n, 4'h0};
        end else begin
            // Slow mode frees one unit every fourth cycle
            gap_r <= slow ? gap_r + 2'h1 : 2'h0;
            credit_freed <= gap_r == 2'h0 && cred_r != 16'h0000;
            pci_retry_event <= gap_r == 2'h0 && retry_r != 16'h0000;
            if (gap_r == 2'h0 && cred_r != 16'h0000) cred_r <= cred_r - 16'h0001;
            if (gap_r == 2'h0 && retry_r != 16'h0000) retry_r <= retry_r - 16'h0001;
        end
    end
    assign busy = cred_r != 16'h0000 || retry_r != 16'h0000 || credit_freed || pci_retry_event;
endmodule
`default_nettype wire
